// File: oaf_pkg.sv
// Constants and types for the operand addressing and flags data path
package oaf_pkg;

    // ****************************************
    // Widths
    // ****************************************
    localparam int          ADDR_W      = 12;
    localparam int          DATA_W      = 8;
    localparam int          NPAIR       = 3;

    // ****************************************
    // Register port indexes
    // ****************************************
    localparam logic [3:0]  REG_FLAGS   = 4'h0;
    localparam logic [3:0]  REG_ACC     = 4'h1;
    localparam logic [3:0]  REG_BANK    = 4'h2;
    localparam logic [3:0]  REG_CFG     = 4'h3;
    localparam logic [3:0]  REG_PTR_LO  = 4'h4;  // Pair n low byte at 4+2n
    localparam logic [3:0]  REG_PTR_TOP = 4'h9;

    // ****************************************
    // Flag fields and reset values
    // ****************************************
    localparam int          FLG_C       = 0;
    localparam int          FLG_DC      = 1;
    localparam int          FLG_Z       = 2;
    localparam int          FLG_OV      = 3;
    localparam int          FLG_N       = 4;
    localparam logic [7:0]  FLAGS_MASK  = 8'h1f;
    localparam logic [7:0]  FLAGS_RST   = 8'h00;
    localparam logic [7:0]  BYTE_RST    = 8'h00;
    localparam int          CFG_EXT     = 0;

    // ****************************************
    // Data memory map
    // ****************************************
    localparam logic [7:0]  ACCESS_SPLIT = 8'h60;
    localparam logic [3:0]  ACCESS_HIGH  = 4'hf;
    localparam logic [11:0] FLAGS_DADDR  = 12'hfd8;
    localparam logic [11:0] IND_BASE     = 12'hfef;
    localparam logic [11:0] IND_STEP     = 12'h008;
    localparam logic [11:0] OPR_PLAIN    = 12'h000;
    localparam logic [11:0] OPR_AFTER_INCREMENT_OPERAND  = 12'h001;
    localparam logic [11:0] OPR_AFTER_DECREMENT_OPERAND  = 12'h002;
    localparam logic [11:0] OPR_BEFORE_INCREMENT_OPERAND   = 12'h003;
    localparam logic [11:0] OPR_OFFSET_BY_ACCUMULATOR_OPERAND    = 12'h004;
    localparam int          LIT_PROG_W   = 20;

    // ****************************************
    // Operations and states
    // ****************************************
    typedef enum logic [3:0] {
        OAF_ADD  = 4'h0,
        OAF_SUB  = 4'h1,
        OAF_AND  = 4'h2,
        OAF_IOR  = 4'h3,
        OAF_XOR  = 4'h4,
        OAF_RRC  = 4'h5,
        OAF_RLC  = 4'h6,
        OAF_MOV  = 4'h7,
        OAF_MOVF = 4'h8
    } oaf_op_e;

    typedef enum logic [2:0] {
        OAF_IDLE = 3'b001,
        OAF_READ = 3'b010,
        OAF_EXEC = 3'b100
    } oaf_state_e;

endpackage

// File: oaf_core.sv
// Flag generation and operand address resolution of the 8-bit core
//
// Our own choices: strobed register access and the address map.
`timescale 1ns/10ps
`default_nettype none

module oaf_core (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        srst,
    // Register port
    input  wire logic [3:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    // Instruction decode side
    input  wire logic        op_start,
    input  wire logic [3:0]  op_kind,
    input  wire logic        op_file,
    input  wire logic [15:0] opcode,
    input  wire logic [15:0] opcode2,
    output logic             op_busy,
    output logic             op_done,
    output logic      [19:0] jump_target,
    // Data memory side
    output logic      [11:0] mem_addr,
    output logic             mem_rd,
    output logic             mem_wr,
    output logic      [7:0]  mem_wdata,
    input  wire logic [7:0]  mem_rdata
);

    // ****************************************
    // State
    // ****************************************
    oaf_pkg::oaf_state_e state_reg;
    logic [7:0]  flags_reg;
    logic [7:0]  acc_reg;
    logic [3:0]  bank_reg;
    logic        ext_reg;
    logic [11:0] ptr_reg [oaf_pkg::NPAIR];
    logic [3:0]  kind_reg;
    logic        file_reg;
    logic        dest_reg;
    logic [7:0]  lit_reg;
    logic [11:0] dst_reg;
    logic        upd_reg;
    logic [1:0]  upd_pair_reg;
    logic [11:0] upd_val_reg;

    // ****************************************
    // Operand address resolution
    // ****************************************
    logic [11:0] raw_addr;
    logic [11:0] eff_addr;
    logic        ind_hit;
    logic [1:0]  ind_pair;
    logic [11:0] ind_sel;
    logic [11:0] ind_new;
    logic [11:0] acc_sx;

    assign acc_sx = {{4{acc_reg[7]}}, acc_reg};

    // Direct address from the low opcode byte
    always_comb begin
        if (opcode[8]) begin
            raw_addr = {bank_reg, opcode[7:0]};
        end else if (ext_reg && opcode[7:0] < oaf_pkg::ACCESS_SPLIT) begin
            raw_addr = ptr_reg[2] + {4'h0, opcode[7:0]};
        end else if (opcode[7:0] < oaf_pkg::ACCESS_SPLIT) begin
            raw_addr = {4'h0, opcode[7:0]};
        end else begin
            raw_addr = {oaf_pkg::ACCESS_HIGH, opcode[7:0]};
        end
    end

    // Virtual pointer operands are looked up across all pairs
    always_comb begin
        logic [11:0] off;
        off      = 12'h000;
        ind_hit  = 1'b0;
        ind_pair = 2'd0;
        ind_sel  = oaf_pkg::OPR_PLAIN;
        for (int p = 0; p < oaf_pkg::NPAIR; p++) begin
            off = oaf_pkg::IND_BASE - 12'(p) * oaf_pkg::IND_STEP - raw_addr;
            if (off <= oaf_pkg::OPR_OFFSET_BY_ACCUMULATOR_OPERAND) begin
                ind_hit  = 1'b1;
                ind_pair = 2'(p);
                ind_sel  = off;
            end
        end
    end

    // Pointer based target, bank and access bit play no part
    always_comb begin
        eff_addr = raw_addr;
        ind_new  = ptr_reg[ind_pair];
        if (ind_hit) begin
            case (ind_sel)
                oaf_pkg::OPR_AFTER_INCREMENT_OPERAND: begin
                    eff_addr = ptr_reg[ind_pair];
                    ind_new  = ptr_reg[ind_pair] + 12'h001;
                end
                oaf_pkg::OPR_AFTER_DECREMENT_OPERAND: begin
                    eff_addr = ptr_reg[ind_pair];
                    ind_new  = ptr_reg[ind_pair] - 12'h001;
                end
                oaf_pkg::OPR_BEFORE_INCREMENT_OPERAND: begin
                    eff_addr = ptr_reg[ind_pair] + 12'h001;
                    ind_new  = eff_addr;
                end
                oaf_pkg::OPR_OFFSET_BY_ACCUMULATOR_OPERAND: begin
                    eff_addr = ptr_reg[ind_pair] + acc_sx;
                end
                default: begin
                    eff_addr = ptr_reg[ind_pair];
                end
            endcase
        end
    end

    // ****************************************
    // Arithmetic and flags
    // ****************************************
    logic [7:0] opnd;
    logic [7:0] addend;
    logic [4:0] lo_sum;
    logic [3:0] mid_sum;
    logic [1:0] top_sum;
    logic [7:0] res;
    logic [7:0] flg_new;
    logic       sets_flags;

    assign opnd = file_reg ? mem_rdata : lit_reg;

    // Subtract is an add of the complement with carry in set
    assign addend  = (oaf_op_sub()) ? ~acc_reg : acc_reg;
    assign lo_sum  = {1'b0, opnd[3:0]} + {1'b0, addend[3:0]} + {4'h0, oaf_op_sub()};
    assign mid_sum = {1'b0, opnd[6:4]} + {1'b0, addend[6:4]} + {3'h0, lo_sum[4]};
    assign top_sum = {1'b0, opnd[7]} + {1'b0, addend[7]} + {1'b0, mid_sum[3]};

    function automatic logic oaf_op_sub();
        return kind_reg == oaf_pkg::OAF_SUB;
    endfunction

    // Result and flag values for the operation in flight
    always_comb begin
        res        = opnd;
        flg_new    = flags_reg;
        sets_flags = 1'b1;
        case (kind_reg)
            oaf_pkg::OAF_ADD, oaf_pkg::OAF_SUB: begin
                res = {top_sum[0], mid_sum[2:0], lo_sum[3:0]};
                flg_new[oaf_pkg::FLG_DC] = lo_sum[4];
                flg_new[oaf_pkg::FLG_C]  = top_sum[1];
                flg_new[oaf_pkg::FLG_OV] = mid_sum[3] ^ top_sum[1];
            end
            oaf_pkg::OAF_AND: res = opnd & acc_reg;
            oaf_pkg::OAF_IOR: res = opnd | acc_reg;
            oaf_pkg::OAF_XOR: res = opnd ^ acc_reg;
            oaf_pkg::OAF_RRC: begin
                res = {flags_reg[oaf_pkg::FLG_C], opnd[7:1]};
                flg_new[oaf_pkg::FLG_C]  = opnd[0];
                flg_new[oaf_pkg::FLG_DC] = opnd[4];
            end
            oaf_pkg::OAF_RLC: begin
                res = {opnd[6:0], flags_reg[oaf_pkg::FLG_C]};
                flg_new[oaf_pkg::FLG_C]  = opnd[7];
                flg_new[oaf_pkg::FLG_DC] = opnd[3];
            end
            oaf_pkg::OAF_MOV: res = opnd;
            default: sets_flags = 1'b0;                           // Full-address moves keep flags unless written to FLAGS_DADDR
        endcase
        if (sets_flags) begin
            flg_new[oaf_pkg::FLG_N] = res[7];
            flg_new[oaf_pkg::FLG_Z] = (res == 8'h00);
        end
        flg_new = flg_new & oaf_pkg::FLAGS_MASK;
    end

    // ****************************************
    // Sequencer
    // ****************************************
    logic exec;
    logic wr_file;
    logic wr_flags_mem;

    assign exec         = (state_reg == oaf_pkg::OAF_EXEC);
    assign wr_file      = exec && file_reg
                          && (kind_reg == oaf_pkg::OAF_MOVF || dest_reg);
    assign wr_flags_mem = wr_file && (mem_addr == oaf_pkg::FLAGS_DADDR);
    assign op_busy      = (state_reg != oaf_pkg::OAF_IDLE);

    // File operands are read first, literals go straight to execute
    always_ff @(posedge clk) begin
        if (srst) begin
            state_reg <= oaf_pkg::OAF_IDLE;
        end else begin
            case (state_reg)
                oaf_pkg::OAF_IDLE: begin
                    if (op_start) begin
                        state_reg <= (op_file || op_kind == oaf_pkg::OAF_MOVF)
                                     ? oaf_pkg::OAF_READ : oaf_pkg::OAF_EXEC;
                    end
                end
                oaf_pkg::OAF_READ: state_reg <= oaf_pkg::OAF_EXEC;
                default:           state_reg <= oaf_pkg::OAF_IDLE;
            endcase
        end
    end

    // Latch the decoded fields when an operation is taken
    always_ff @(posedge clk) begin
        if (srst) begin
            kind_reg     <= 4'h0;
            file_reg     <= 1'b0;
            dest_reg     <= 1'b0;
            lit_reg      <= oaf_pkg::BYTE_RST;
            dst_reg      <= 12'h000;
            jump_target  <= 20'h00000;
            upd_reg      <= 1'b0;
            upd_pair_reg <= 2'd0;
            upd_val_reg  <= 12'h000;
        end else if (state_reg == oaf_pkg::OAF_IDLE && op_start) begin
            kind_reg     <= op_kind;
            file_reg     <= op_file || op_kind == oaf_pkg::OAF_MOVF;
            dest_reg     <= opcode[9];
            lit_reg      <= opcode[7:0];
            dst_reg      <= opcode2[11:0];
            jump_target  <= {opcode2[11:0], opcode[7:0]};
            upd_reg      <= op_file && op_kind != oaf_pkg::OAF_MOVF && ind_hit
                            && ind_sel != oaf_pkg::OPR_PLAIN && ind_sel != oaf_pkg::OPR_OFFSET_BY_ACCUMULATOR_OPERAND;
            upd_pair_reg <= ind_pair;
            upd_val_reg  <= ind_new;
        end else if (exec) begin
            upd_reg <= 1'b0;
        end
    end

    // Memory strobes and the address for each phase
    always_ff @(posedge clk) begin
        if (srst) begin
            mem_addr  <= 12'h000;
            mem_rd    <= 1'b0;
            mem_wr    <= 1'b0;
            mem_wdata <= oaf_pkg::BYTE_RST;
            op_done   <= 1'b0;
        end else begin
            mem_rd  <= 1'b0;
            mem_wr  <= 1'b0;
            op_done <= exec;
            if (state_reg == oaf_pkg::OAF_IDLE && op_start) begin
                if (op_kind == oaf_pkg::OAF_MOVF) begin
                    mem_addr <= opcode[11:0];
                    mem_rd   <= 1'b1;
                end else if (op_file) begin
                    mem_addr <= eff_addr;
                    mem_rd   <= 1'b1;
                end
            end else if (state_reg == oaf_pkg::OAF_READ && kind_reg == oaf_pkg::OAF_MOVF) begin
                mem_addr <= dst_reg;
            end
            if (state_reg == oaf_pkg::OAF_READ) begin
                mem_wr <= kind_reg == oaf_pkg::OAF_MOVF || dest_reg;
            end
            if (exec) begin
                mem_wdata <= res;
            end
        end
    end

    // ****************************************
    // Registers
    // ****************************************
    logic       ptr_wr;
    logic [1:0] ptr_idx;
    logic [3:0] ptr_off;

    assign ptr_off = reg_addr - oaf_pkg::REG_PTR_LO;
    assign ptr_idx = ptr_off[2:1];
    assign ptr_wr  = reg_wr && reg_addr >= oaf_pkg::REG_PTR_LO
                     && reg_addr <= oaf_pkg::REG_PTR_TOP;

    // Flags: the operation's own update wins over any data write
    always_ff @(posedge clk) begin
        if (srst) begin
            flags_reg <= oaf_pkg::FLAGS_RST;
        end else if (exec && sets_flags) begin
            flags_reg <= flg_new;
        end else if (exec && wr_flags_mem) begin
            flags_reg <= res & oaf_pkg::FLAGS_MASK;
        end else if (reg_wr && reg_addr == oaf_pkg::REG_FLAGS) begin
            flags_reg <= reg_wdata & oaf_pkg::FLAGS_MASK;
        end
    end

    // Accumulator takes literal results and file results whose destination bit is clear
    always_ff @(posedge clk) begin
        if (srst) begin
            acc_reg <= oaf_pkg::BYTE_RST;
        end else if (exec && !wr_file) begin
            acc_reg <= res;
        end else if (reg_wr && reg_addr == oaf_pkg::REG_ACC) begin
            acc_reg <= reg_wdata;
        end
    end

    // Bank select and configuration
    always_ff @(posedge clk) begin
        if (srst) begin
            bank_reg <= 4'h0;
            ext_reg  <= 1'b0;
        end else begin
            if (reg_wr && reg_addr == oaf_pkg::REG_BANK) begin
                bank_reg <= reg_wdata[3:0];
            end
            if (reg_wr && reg_addr == oaf_pkg::REG_CFG) begin
                ext_reg <= reg_wdata[oaf_pkg::CFG_EXT];
            end
        end
    end

    // One 12-bit pointer per pair; software bytes and automatic steps
    for (genvar g = 0; g < oaf_pkg::NPAIR; g++) begin : g_ptr
        always_ff @(posedge clk) begin
            if (srst) begin
                ptr_reg[g] <= 12'h000;
            end else if (exec && upd_reg && upd_pair_reg == 2'(g)) begin
                ptr_reg[g] <= upd_val_reg;
            end else if (ptr_wr && ptr_idx == 2'(g)) begin
                if (ptr_off[0]) begin
                    ptr_reg[g][11:8] <= reg_wdata[3:0];
                end else begin
                    ptr_reg[g][7:0] <= reg_wdata;
                end
            end
        end
    end

    // Read data stands in the cycle after the read strobe
    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= oaf_pkg::BYTE_RST;
        end else if (reg_rd) begin
            case (reg_addr)
                oaf_pkg::REG_FLAGS: reg_rdata <= flags_reg & oaf_pkg::FLAGS_MASK;
                oaf_pkg::REG_ACC:   reg_rdata <= acc_reg;
                oaf_pkg::REG_BANK:  reg_rdata <= {4'h0, bank_reg};
                oaf_pkg::REG_CFG:   reg_rdata <= {7'h00, ext_reg};
                4'h4, 4'h6, 4'h8:   reg_rdata <= ptr_reg[ptr_idx][7:0];
                4'h5, 4'h7, 4'h9:   reg_rdata <= {4'h0, ptr_reg[ptr_idx][11:8]};
                default:            reg_rdata <= oaf_pkg::BYTE_RST;
            endcase
        end
    end

endmodule // oaf_core

`default_nettype wire

// File: oaf_core_asserts.sv
// Port-level property checker for the flags and addressing core
`timescale 1ns/10ps
`default_nettype none
module oaf_core_chk (
    // Clock and reset
    input wire logic        clk,
    input wire logic        srst,
    // Register port
    input wire logic [3:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic [7:0]  reg_rdata,
    // Decode side
    input wire logic        op_start,
    input wire logic [3:0]  op_kind,
    input wire logic        op_file,
    input wire logic [15:0] opcode,
    input wire logic [15:0] opcode2,
    input wire logic        op_busy,
    input wire logic        op_done,
    input wire logic [19:0] jump_target,
    // Memory side
    input wire logic [11:0] mem_addr,
    input wire logic        mem_rd,
    input wire logic        mem_wr,
    input wire logic [7:0]  mem_wdata,
    input wire logic [7:0]  mem_rdata
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    // Taken starts; upper access-bank operands stop short of the flag and pointer slots
    wire go   = op_start && !op_busy;
    wire fop  = go && op_file && op_kind != 4'h8;
    wire hi_f = !opcode[8] && opcode[7:0] >= 8'h60 && opcode[7:0] < 8'hd8;

    flags_top_zero_a: assert property (reg_rd && reg_addr == 4'h0 |=> reg_rdata[7:5] == 3'h0)
        else $error("flag top bits not zero");
    ptr_high_zero_a: assert property (reg_rd && reg_addr inside {4'h5, 4'h7, 4'h9} |=> reg_rdata[7:4] == 4'h0)
        else $error("pointer high nibble not zero");
    jump_capture_a: assert property (go |=> jump_target == {$past(opcode2[11:0]), $past(opcode[7:0])})
        else $error("jump target wrong");
    access_high_a: assert property (fop && hi_f |=> mem_rd && mem_addr == {4'hf, $past(opcode[7:0])})
        else $error("access bank address wrong");
    full_move_a: assert property (go && op_kind == 4'h8 |=> (mem_rd && mem_addr == $past(opcode[11:0]))
        ##1 (mem_wr && mem_addr == $past(opcode2[11:0], 2))) else $error("full move addresses wrong");
    dest_acc_a: assert property (fop && !opcode[9] |=> !mem_wr [*3])
        else $error("write with destination bit zero");
    dest_file_a: assert property (fop && opcode[9] && hi_f |-> ##2 mem_wr
        ##1 (op_done && mem_addr == {4'hf, $past(opcode[7:0], 3)})) else $error("write back missing");
    file_done_a: assert property (go && (op_file || op_kind == 4'h8) |-> ##3 op_done)
        else $error("file operation late");
    lit_done_a: assert property (go && !op_file && op_kind != 4'h8 |=> !mem_rd ##1 (op_done && !op_busy))
        else $error("literal operation wrong");
endmodule // oaf_core_chk

bind oaf_core oaf_core_chk u_chk (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .op_start(op_start), .op_kind(op_kind), .op_file(op_file), .opcode(opcode),
    .opcode2(opcode2), .op_busy(op_busy), .op_done(op_done), .jump_target(jump_target),
    .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata));
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the flags and addressing core
`timescale 1ns/10ps
`default_nettype none
module testbench;
    // ********
    // Signals
    // ********
    logic        clk = 1'b0, srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
    logic        op_start = 1'b0, op_file = 1'b0, op_busy, op_done, mem_rd, mem_wr;
    logic [3:0]  reg_addr = 4'h0, op_kind = 4'h0;
    logic [7:0]  reg_wdata = 8'h00, reg_rdata, mem_wdata, mem_rdata = 8'h00;
    logic [15:0] opcode = 16'h0000, opcode2 = 16'h0000;
    logic [19:0] jump_target;
    logic [11:0] mem_addr;
    logic [7:0]  mem [4096];
    logic [7:0]  eq [$], mq [$], dq [$];
    logic [11:0] aq [$];
    logic        rd_d = 1'b0, wr_d = 1'b0;
    int          err_total = 0, check_count = 0, cyc = 0;

    oaf_core DUT (.clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .op_start(op_start),
        .op_kind(op_kind), .op_file(op_file), .opcode(opcode), .opcode2(opcode2),
        .op_busy(op_busy), .op_done(op_done), .jump_target(jump_target),
        .mem_addr(mem_addr), .mem_rd(mem_rd), .mem_wr(mem_wr), .mem_wdata(mem_wdata),
        .mem_rdata(mem_rdata));

    // 20 MHz clock
    initial forever #25 clk = ~clk;

    // ********
    // Memory and watcher
    // ********
    // One-cycle memory; idle read data flips so stale bytes never pass
    always @(posedge clk) begin
        wr_d <= mem_wr;
        if (mem_rd)
            mem_rdata <= mem[mem_addr];
        else
            mem_rdata <= ~mem_rdata;
        if (wr_d)
            mem[mem_addr] <= mem_wdata;
    end
    // Oldest note is matched against each read answer and each write
    always @(posedge clk) begin
        rd_d <= reg_rd;
        if (rd_d)
            chk8("reg_rdata", eq.pop_front(), mq.pop_front(), reg_rdata);
        if (wr_d) begin
            chk12("mem_addr", aq.pop_front(), mem_addr);
            chk8("mem_wdata", dq.pop_front(), 8'hff, mem_wdata);
        end
    end
    // Hang guard, well above the expected run
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            err_total++;
            test_done();
        end
    end

    // ********
    // Tasks
    // ********
    task automatic chk8(input string n, input logic [7:0] e, m, g);
        check_count++;
        if ((g & m) !== (e & m)) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e & m, g);
        end
    endtask
    task automatic chk12(input string n, input logic [11:0] e, g);
        check_count++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e, m);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        eq.push_back(e);
        mq.push_back(m);
        @(posedge clk);
        reg_rd <= 1'b0;
    endtask
    task automatic ptr(input int n, input logic [11:0] v);
        wr(4'(oaf_pkg::REG_PTR_LO + 2 * n), v[7:0]);
        wr(4'(oaf_pkg::REG_PTR_LO + 2 * n + 1), {4'h0, v[11:8]});
    endtask
    // A second start while busy must be ignored
    task automatic op(input logic [3:0] k, input logic f, input logic [15:0] o, o2);
        @(posedge clk);
        op_kind <= k;
        op_file <= f;
        opcode <= o;
        opcode2 <= o2;
        op_start <= 1'b1;
        @(posedge clk);
        op_start <= 1'($urandom % 2);
        @(posedge clk);
        op_start <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            if (op_done === 1'b1)
                break;
        end
        chk8("op_done", 8'h01, 8'h01, {7'h00, op_done});
        chk12("jump_target high", o2[11:0], jump_target[19:8]);
        chk12("jump_target low", {4'h0, o[7:0]}, {4'h0, jump_target[7:0]});
    endtask
    task automatic test_done();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Reference result: {N, OV, Z, DC, C, byte}
    function automatic logic [12:0] alu(input logic [3:0] k, input logic [7:0] s, w,
                                        input logic [4:0] fl);
        logic [7:0] b, x, m;
        logic [8:0] r;
        logic [4:0] lo;
        b = (k == 4'h1) ? ~w : w;
        r = s + b + (k == 4'h1);
        lo = s[3:0] + b[3:0] + (k == 4'h1);
        m = s[6:0] + b[6:0] + (k == 4'h1);
        x = (k == 4'h2) ? s & w : (k == 4'h3) ? s | w : (k == 4'h4) ? s ^ w : s;
        if (k < 4'h2)
            return {r[7], m[7] ^ r[8], r[7:0] == 8'h00, lo[4], r[8], r[7:0]};
        if (k == 4'h5)
            return {fl[0], fl[3], {fl[0], s[7:1]} == 8'h00, s[4], s[0], fl[0], s[7:1]};
        if (k == 4'h6)
            return {s[6], fl[3], {s[6:0], fl[0]} == 8'h00, s[3], s[7], s[6:0], fl[0]};
        return {x[7], fl[3], x == 8'h00, fl[1:0], x};
    endfunction

    // ********
    // Main sequence
    // ********
    initial begin
        logic [3:0] k, b;
        logic [7:0] f, s, w;
        logic [11:0] ea, src;
        logic [11:0] p [3];
        logic [4:0] fl;
        logic [12:0] r;
        int md, n, q;
        logic d;
        void'($urandom(45535));
        foreach (mem[i])
            mem[i] = 8'($urandom);
        repeat (5) @(posedge clk);
        srst <= 1'b0;
        // Reset values, unmapped index, unimplemented bits
        for (int i = 0; i < 16; i++)
            rd(4'(i), 8'h00, 8'hff);
        wr(4'h0, 8'hff);
        rd(4'h0, 8'h1f, 8'hff);
        wr(4'h5, 8'hff);
        rd(4'h5, 8'h0f, 8'hff);
        wr(4'hc, 8'h5a);
        rd(4'hc, 8'h00, 8'hff);
        fl = 5'h1f;
        w = 8'h00;
        // Random mix of addressing modes and operations
        for (int t = 0; t < 300; t++) begin
            md = $urandom % 7;
            k = 4'($urandom % 7);
            d = 1'($urandom);
            f = 8'($urandom);
            b = 4'($urandom % 15);
            q = 0;
            wr(4'h2, {4'h0, b});
            wr(4'h3, {7'h00, md == 3});
            case (md)
                0: ea = {b, f};
                1: begin
                    f = f % 8'h60;
                    ea = {4'h0, f};
                end
                2: begin
                    f = 8'h60 + f % 8'h70;
                    ea = {4'hf, f};
                end
                3: begin
                    f = f % 8'h60;
                    p[2] = 12'($urandom % 'hd00);
                    ptr(2, p[2]);
                    ea = p[2] + f;
                end
                4: begin
                    n = $urandom % 3;
                    q = $urandom % 5;
                    ea = 12'h100 + 12'($urandom % 'hd00);
                    if (ea[9])
                        ea[7:0] = {8{ea[0]}}; // Byte edge, carry into high byte
                    p[n] = ea;
                    ptr(n, ea);
                    f = 8'(oaf_pkg::IND_BASE - oaf_pkg::IND_STEP * n - q);
                    if (q == 3)
                        ea = ea + 12'h001;
                    if (q == 4)
                        ea = ea + {{4{w[7]}}, w};
                    if (q == 1 || q == 3)
                        p[n] = p[n] + 12'h001;
                    if (q == 2)
                        p[n] = p[n] - 12'h001;
                end
                default: if (k > 4'h4) k = 4'h7;
            endcase
            if (md == 6) begin
                src = 12'($urandom % 'he00);
                ea = 12'($urandom % 'he00);
                aq.push_back(ea);
                dq.push_back(mem[src]);
                op(4'h8, 1'b0, {4'h0, src}, {4'h0, ea});
            end else begin
                s = (md == 5) ? f : mem[ea];
                r = alu(k, s, w, fl);
                if (md != 5 && d) begin
                    aq.push_back(ea);
                    dq.push_back(r[7:0]);
                end else
                    w = r[7:0];
                op(k, md != 5, {6'h00, d, md == 0, f}, 16'($urandom));
                fl = r[12:8];
            end
            rd(4'h0, {3'h0, fl}, 8'hff);
            rd(4'h1, w, 8'hff);
            if (md == 4) begin
                rd(4'(4 + 2 * n), p[n][7:0], 8'hff);
                rd(4'(5 + 2 * n), {4'h0, p[n][11:8]}, 8'hff);
            end
        end
        // Flag register as destination: the operation's own flags win
        s = mem[12'hfd8];
        r = alu(4'h0, s, w, fl);
        aq.push_back(12'hfd8);
        dq.push_back(r[7:0]);
        op(4'h0, 1'b1, 16'h02d8, 16'h0000);
        fl = r[12:8];
        rd(4'h0, {3'h0, fl}, 8'hff);
        // A full-address move into it loads the low five bits
        s = mem[12'h010];
        aq.push_back(12'hfd8);
        dq.push_back(s);
        op(4'h8, 1'b0, 16'h0010, 16'h0fd8);
        rd(4'h0, {3'h0, s[4:0]}, 8'hff);
        repeat (4) @(posedge clk);
        chk12("writes left", 12'h000, 12'(aq.size()));
        test_done();
    end
endmodule // testbench
`default_nettype wire
